// File: hw/pin_change_detector.v
// pin-change interrupt block with AHB-Lite register slave
// Summary of operation
// - Change detection exists on all pins of groups a, b, c and on pin three of group e only.
// - Every pin is independently selectable as a change-interrupt source.
// - The change and wake requests are raised only with the master enable set, while detection runs whether or not it is set.
// - Each pin has a rising-edge detector gated by its rise enable bit.
// - Each pin has a falling-edge detector gated by its fall enable bit.
// - With both enables set a pin detects both polarities.
// - A detected enabled edge sets the pin flag and requests an interrupt if enabled.
// - The summary flag is the OR of all pin flags and is read-only.
// - Writing zero to a pin flag bit clears it.
// - An edge in the same cycle as a flag write leaves that flag set.
// - The wake request is the change interrupt or, with the master enable set, any enabled edge, and flags set on the same clock edge that raises the wake request.
// - Bit 0 of the module disable register turns the whole block off.
// - While off, the block is held in reset and, except for the module disable register, ignores writes and reads zero.
`timescale 1ns/1ps
`include "pin_change_map.vh"
module pin_change_detector #(
  parameter GROUP_WIDTH = 8
) (
  input  wire                   SYS_CLK,
  input  wire                   RST_N,
  input  wire [GROUP_WIDTH-1:0] PIN_GROUP_A,
  input  wire [GROUP_WIDTH-1:0] PIN_GROUP_B,
  input  wire [GROUP_WIDTH-1:0] PIN_GROUP_C,
  input  wire                   GROUP_E_PIN_THREE,
  input  wire                   HSEL,
  input  wire [31:0]            HADDR,
  input  wire [1:0]             HTRANS,
  input  wire                   HWRITE,
  input  wire [2:0]             HSIZE,
  input  wire [31:0]            HWDATA,
  input  wire                   HREADY,
  output reg  [31:0]            HRDATA,
  output reg                    HREADYOUT,
  output reg                    HRESP,
  output reg                    CHANGE_IRQ,
  output reg                    WAKE_REQ,
  output reg                    IRQ
);

  // ****************************************************************
  // bus address phase capture
  // ****************************************************************
  reg        wr_pend;
  reg        rd_pend;
  reg [11:0] addr_q;
  wire       take = HSEL & HREADY & HTRANS[1];

  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      addr_q  <= 12'h000;
    end else begin
      wr_pend <= take & HWRITE;
      rd_pend <= take & ~HWRITE;
      if (take)
        addr_q <= {HADDR[11:2], 2'b00};
    end
  end

  // ****************************************************************
  // module disable; held outside the block reset so it can be cleared
  // ****************************************************************
  reg  module_off;
  wire wr_en = wr_pend;

  always @(posedge SYS_CLK) begin
    if (!RST_N)
      module_off <= 1'b0;
    else if (wr_en && addr_q == `PC_OFF_MOD_DIS)
      module_off <= HWDATA[`PC_MODULE_OFF_BIT];
  end

  // ****************************************************************
  // block reset and write gate
  // ****************************************************************
  // block held in reset while disabled
  wire blk_rst_n = RST_N & ~module_off;
  wire blk_wr    = wr_en & ~module_off;

  // ****************************************************************
  // control registers
  // ****************************************************************
  reg [GROUP_WIDTH-1:0] rise_a;
  reg [GROUP_WIDTH-1:0] fall_a;
  reg [GROUP_WIDTH-1:0] rise_b;
  reg [GROUP_WIDTH-1:0] fall_b;
  reg [GROUP_WIDTH-1:0] rise_c;
  reg [GROUP_WIDTH-1:0] fall_c;
  reg                   rise_e;
  reg                   fall_e;
  reg                   master_en;
  reg [1:0]             ev_mask;
  reg [1:0]             next_ev_mask;

  always @(posedge SYS_CLK) begin
    if (!blk_rst_n) begin
      rise_a    <= `PC_RST_BYTE;
      fall_a    <= `PC_RST_BYTE;
      rise_b    <= `PC_RST_BYTE;
      fall_b    <= `PC_RST_BYTE;
      rise_c    <= `PC_RST_BYTE;
      fall_c    <= `PC_RST_BYTE;
      rise_e    <= 1'b0;
      fall_e    <= 1'b0;
      master_en <= 1'b0;
    end else if (blk_wr) begin
      case (addr_q)
        `PC_OFF_RISE_A: rise_a <= HWDATA[GROUP_WIDTH-1:0];
        `PC_OFF_FALL_A: fall_a <= HWDATA[GROUP_WIDTH-1:0];
        `PC_OFF_RISE_B: rise_b <= HWDATA[GROUP_WIDTH-1:0];
        `PC_OFF_FALL_B: fall_b <= HWDATA[GROUP_WIDTH-1:0];
        `PC_OFF_RISE_C: rise_c <= HWDATA[GROUP_WIDTH-1:0];
        `PC_OFF_FALL_C: fall_c <= HWDATA[GROUP_WIDTH-1:0];
        `PC_OFF_RISE_E: rise_e <= HWDATA[`PC_GROUP_E_PIN];
        `PC_OFF_FALL_E: fall_e <= HWDATA[`PC_GROUP_E_PIN];
        `PC_OFF_IRQ_EN: master_en <= HWDATA[`PC_MASTER_EN_BIT];
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // event mask, next value shared with the irq output
  // ****************************************************************
  always @* begin
    next_ev_mask = ev_mask;
    if (blk_wr && addr_q == `PC_OFF_IRQ_MASK)
      next_ev_mask = HWDATA[1:0];
  end

  always @(posedge SYS_CLK) begin
    if (!blk_rst_n)
      ev_mask <= `PC_RST_EV;
    else
      ev_mask <= next_ev_mask;
  end

  // ****************************************************************
  // pin synchronisers and detectors
  // ****************************************************************
  wire [GROUP_WIDTH-1:0] sync_a;
  wire [GROUP_WIDTH-1:0] sync_b;
  wire [GROUP_WIDTH-1:0] sync_c;
  wire                   sync_e;
  wire [GROUP_WIDTH-1:0] flag_a;
  wire [GROUP_WIDTH-1:0] flag_b;
  wire [GROUP_WIDTH-1:0] flag_c;
  wire                   flag_e;
  wire                   edge_a;
  wire                   edge_b;
  wire                   edge_c;
  wire                   edge_e;

  pin_sync #(.WIDTH(3*GROUP_WIDTH+1)) u_sync (
    .clk   (SYS_CLK),
    .rst_n (blk_rst_n),
    .din   ({GROUP_E_PIN_THREE, PIN_GROUP_C, PIN_GROUP_B, PIN_GROUP_A}),
    .dout  ({sync_e, sync_c, sync_b, sync_a})
  );

  // ****************************************************************
  // per-group edge detectors and flags
  // ****************************************************************

  edge_flag_group #(.WIDTH(GROUP_WIDTH)) u_grp_a (
    .clk        (SYS_CLK),
    .rst_n      (blk_rst_n),
    .pins_sync  (sync_a),
    .rise_en    (rise_a),
    .fall_en    (fall_a),
    .flag_wr    (blk_wr && addr_q == `PC_OFF_FLAG_A),
    .flag_wdata (HWDATA[GROUP_WIDTH-1:0]),
    .flags      (flag_a),
    .any_edge   (edge_a)
  );

  edge_flag_group #(.WIDTH(GROUP_WIDTH)) u_grp_b (
    .clk        (SYS_CLK),
    .rst_n      (blk_rst_n),
    .pins_sync  (sync_b),
    .rise_en    (rise_b),
    .fall_en    (fall_b),
    .flag_wr    (blk_wr && addr_q == `PC_OFF_FLAG_B),
    .flag_wdata (HWDATA[GROUP_WIDTH-1:0]),
    .flags      (flag_b),
    .any_edge   (edge_b)
  );

  edge_flag_group #(.WIDTH(GROUP_WIDTH)) u_grp_c (
    .clk        (SYS_CLK),
    .rst_n      (blk_rst_n),
    .pins_sync  (sync_c),
    .rise_en    (rise_c),
    .fall_en    (fall_c),
    .flag_wr    (blk_wr && addr_q == `PC_OFF_FLAG_C),
    .flag_wdata (HWDATA[GROUP_WIDTH-1:0]),
    .flags      (flag_c),
    .any_edge   (edge_c)
  );

  edge_flag_group #(.WIDTH(1)) u_grp_e (
    .clk        (SYS_CLK),
    .rst_n      (blk_rst_n),
    .pins_sync  (sync_e),
    .rise_en    (rise_e),
    .fall_en    (fall_e),
    .flag_wr    (blk_wr && addr_q == `PC_OFF_FLAG_E),
    .flag_wdata (HWDATA[`PC_GROUP_E_PIN]),
    .flags      (flag_e),
    .any_edge   (edge_e)
  );

  // ****************************************************************
  // summary flag and any-edge
  // ****************************************************************
  wire summary = (|flag_a) | (|flag_b) | (|flag_c) | flag_e;
  wire any_hit = edge_a | edge_b | edge_c | edge_e;

  // ****************************************************************
  // event status and interrupt output
  // ****************************************************************
  reg  [1:0] ev_stat;
  wire       stat_wr      = blk_wr && addr_q == `PC_OFF_IRQ_STAT;
  wire [1:0] ev_set       = {any_hit & master_en, any_hit};
  wire [1:0] stat_clr     = stat_wr ? HWDATA[1:0] : 2'b00;
  // set wins over write-one-to-clear
  wire [1:0] next_ev_stat = (ev_stat & ~stat_clr) | ev_set;

  // irq follows the status and mask values loaded at this edge
  always @(posedge SYS_CLK) begin
    if (!blk_rst_n) begin
      ev_stat <= `PC_RST_EV;
      IRQ     <= 1'b0;
    end else begin
      ev_stat <= next_ev_stat;
      IRQ     <= |(next_ev_stat & next_ev_mask);
    end
  end

  // ****************************************************************
  // change request and wake outputs
  // ****************************************************************
  always @(posedge SYS_CLK) begin
    if (!blk_rst_n) begin
      CHANGE_IRQ <= 1'b0;
      WAKE_REQ   <= 1'b0;
    end else begin
      CHANGE_IRQ <= master_en & summary;
      WAKE_REQ   <= master_en & (summary | any_hit);
    end
  end

  // ****************************************************************
  // read data and bus response
  // ****************************************************************
  reg [31:0] next_rdata;

  always @* begin
    next_rdata = `PC_RST_WORD;
    case (addr_q)
      `PC_OFF_RISE_A:   next_rdata[GROUP_WIDTH-1:0] = rise_a;
      `PC_OFF_FALL_A:   next_rdata[GROUP_WIDTH-1:0] = fall_a;
      `PC_OFF_FLAG_A:   next_rdata[GROUP_WIDTH-1:0] = flag_a;
      `PC_OFF_RISE_B:   next_rdata[GROUP_WIDTH-1:0] = rise_b;
      `PC_OFF_FALL_B:   next_rdata[GROUP_WIDTH-1:0] = fall_b;
      `PC_OFF_FLAG_B:   next_rdata[GROUP_WIDTH-1:0] = flag_b;
      `PC_OFF_RISE_C:   next_rdata[GROUP_WIDTH-1:0] = rise_c;
      `PC_OFF_FALL_C:   next_rdata[GROUP_WIDTH-1:0] = fall_c;
      `PC_OFF_FLAG_C:   next_rdata[GROUP_WIDTH-1:0] = flag_c;
      `PC_OFF_RISE_E:   next_rdata[`PC_GROUP_E_PIN] = rise_e;
      `PC_OFF_FALL_E:   next_rdata[`PC_GROUP_E_PIN] = fall_e;
      `PC_OFF_FLAG_E:   next_rdata[`PC_GROUP_E_PIN] = flag_e;
      `PC_OFF_IRQ_EN:   next_rdata[`PC_MASTER_EN_BIT] = master_en;
      `PC_OFF_IRQ_FLAG: next_rdata[`PC_SUMMARY_BIT] = summary;
      `PC_OFF_IRQ_STAT: next_rdata[1:0] = ev_stat;
      `PC_OFF_IRQ_MASK: next_rdata[1:0] = ev_mask;
      default:          next_rdata = `PC_RST_WORD;
    endcase
    if (module_off)
      next_rdata = `PC_RST_WORD;
    if (addr_q == `PC_OFF_MOD_DIS)
      next_rdata[`PC_MODULE_OFF_BIT] = module_off;
  end

  // ****************************************************************
  // bus response
  // ****************************************************************
  // two-cycle answer: address captured, then data presented
  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      HRDATA    <= `PC_RST_WORD;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end else begin
      HRESP <= 1'b0;
      if (take) begin
        HREADYOUT <= 1'b0;
      end else if (rd_pend) begin
        HRDATA    <= next_rdata;
        HREADYOUT <= 1'b1;
      end else begin
        HREADYOUT <= 1'b1;
      end
    end
  end
endmodule // pin_change_detector

// File: hw/pin_change_map.vh
// register offsets, field positions, reset values and timing counts of the pin-change block
`ifndef PIN_CHANGE_MAP_VH
`define PIN_CHANGE_MAP_VH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define PC_OFF_RISE_A    12'h000
`define PC_OFF_FALL_A    12'h004
`define PC_OFF_FLAG_A    12'h008
`define PC_OFF_RISE_B    12'h00C
`define PC_OFF_FALL_B    12'h010
`define PC_OFF_FLAG_B    12'h014
`define PC_OFF_RISE_C    12'h018
`define PC_OFF_FALL_C    12'h01C
`define PC_OFF_FLAG_C    12'h020
`define PC_OFF_RISE_E    12'h024
`define PC_OFF_FALL_E    12'h028
`define PC_OFF_FLAG_E    12'h02C
`define PC_OFF_IRQ_EN    12'h030
`define PC_OFF_IRQ_FLAG  12'h034
`define PC_OFF_MOD_DIS   12'h038
`define PC_OFF_IRQ_STAT  12'h03C
`define PC_OFF_IRQ_MASK  12'h040

// ****************************************************************
// field positions
// ****************************************************************
`define PC_MASTER_EN_BIT  0
`define PC_SUMMARY_BIT    0
`define PC_MODULE_OFF_BIT 0
`define PC_GROUP_E_PIN    3
`define PC_EV_CHANGE_BIT  0
`define PC_EV_WAKE_BIT    1

// ****************************************************************
// reset values
// ****************************************************************
`define PC_RST_BYTE  8'h00
`define PC_RST_EV    2'h0
`define PC_RST_WORD  32'h0000_0000

`define PC_SYNC_STAGES 2

`endif

// File: hw/pin_sync.v
// two-flop synchroniser for a vector of pins
`timescale 1ns/1ps
module pin_sync #(
  parameter WIDTH = 8
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire [WIDTH-1:0] din,
  output reg  [WIDTH-1:0] dout
);
  reg [WIDTH-1:0] meta;

  always @(posedge clk) begin
    if (!rst_n) begin
      meta <= {WIDTH{1'b0}};
      dout <= {WIDTH{1'b0}};
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule // pin_sync

// File: hw/edge_flag_group.v
// per-pin edge detection and flag register for one group of pins
`timescale 1ns/1ps
module edge_flag_group #(
  parameter WIDTH = 8
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire [WIDTH-1:0] pins_sync,
  input  wire [WIDTH-1:0] rise_en,
  input  wire [WIDTH-1:0] fall_en,
  input  wire             flag_wr,
  input  wire [WIDTH-1:0] flag_wdata,
  output reg  [WIDTH-1:0] flags,
  output wire             any_edge
);
  reg  [WIDTH-1:0] prev;
  wire [WIDTH-1:0] hit;

  // compare current sample with previous one
  assign hit = (pins_sync & ~prev & rise_en)
             | (~pins_sync & prev & fall_en);
  assign any_edge = |hit;

  always @(posedge clk) begin
    if (!rst_n) begin
      prev  <= {WIDTH{1'b0}};
      flags <= {WIDTH{1'b0}};
    end else begin
      prev <= pins_sync;
      if (flag_wr)
        flags <= flag_wdata | hit;
      else
        flags <= flags | hit;
    end
  end
endmodule // edge_flag_group

// File: sim/pin_change_chk.sv
// concurrent checks on the pin-change block ports
`timescale 1ns/1ps
module pin_change_chk #(
  parameter GROUP_WIDTH = 8
) (
  input wire                   SYS_CLK,
  input wire                   RST_N,
  input wire [GROUP_WIDTH-1:0] PIN_GROUP_A,
  input wire [GROUP_WIDTH-1:0] PIN_GROUP_B,
  input wire [GROUP_WIDTH-1:0] PIN_GROUP_C,
  input wire                   GROUP_E_PIN_THREE,
  input wire                   HSEL,
  input wire [1:0]             HTRANS,
  input wire                   HREADY,
  input wire [31:0]            HRDATA,
  input wire                   HREADYOUT,
  input wire                   HRESP,
  input wire                   CHANGE_IRQ,
  input wire                   WAKE_REQ,
  input wire                   IRQ
);
  // quiet counts cycles since the last pin change or bus request
  logic [3:0]               quiet;
  logic [3*GROUP_WIDTH:0]   last_pins;
  wire  [3*GROUP_WIDTH:0]   pins  = {GROUP_E_PIN_THREE, PIN_GROUP_C, PIN_GROUP_B, PIN_GROUP_A};
  wire                      taken = HSEL & HREADY & HTRANS[1];
  always @(posedge SYS_CLK) begin
    last_pins <= pins;
    if (!RST_N || taken || pins != last_pins)
      quiet <= 4'h0;
    else if (quiet != 4'hF)
      quiet <= quiet + 4'h1;
  end
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  property p_resp; HRESP == 1'b0; endproperty
  property p_wait; taken && HREADYOUT |=> !HREADYOUT ##1 HREADYOUT; endproperty
  property p_ready_cause; !HREADYOUT |-> $past(taken); endproperty
  property p_rdata_hold; !$rose(HREADYOUT) |-> $stable(HRDATA); endproperty
  property p_rst;
    disable iff (1'b0) !RST_N |=> HREADYOUT && !IRQ && !CHANGE_IRQ && !WAKE_REQ;
  endproperty
  property p_wake; CHANGE_IRQ |-> WAKE_REQ; endproperty
  property p_quiet_chg; quiet > 4'h7 |-> $stable(CHANGE_IRQ); endproperty
  property p_quiet_irq; quiet > 4'h7 |-> $stable(IRQ); endproperty
  property p_quiet_wake; quiet > 4'h7 |-> $stable(WAKE_REQ); endproperty
  a_resp: assert property (p_resp) else $error("bus response not okay");
  a_wait: assert property (p_wait) else $error("data phase length wrong");
  a_ready_cause: assert property (p_ready_cause) else $error("wait state without request");
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data changed");
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  a_wake: assert property (p_wake) else $error("change irq without wake");
  a_quiet_chg: assert property (p_quiet_chg) else $error("change irq moved");
  a_quiet_irq: assert property (p_quiet_irq) else $error("irq moved while quiet");
  a_quiet_wake: assert property (p_quiet_wake) else $error("wake moved");
  c_chg: cover property ($rose(CHANGE_IRQ));
  c_irq: cover property ($rose(IRQ));
  c_rd: cover property (taken ##2 HREADYOUT);
endmodule // pin_change_chk

bind pin_change_detector pin_change_chk #(.GROUP_WIDTH(GROUP_WIDTH)) i_chk (
  .SYS_CLK(SYS_CLK), .RST_N(RST_N), .PIN_GROUP_A(PIN_GROUP_A), .PIN_GROUP_B(PIN_GROUP_B),
  .PIN_GROUP_C(PIN_GROUP_C), .GROUP_E_PIN_THREE(GROUP_E_PIN_THREE), .HSEL(HSEL),
  .HTRANS(HTRANS), .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
  .CHANGE_IRQ(CHANGE_IRQ), .WAKE_REQ(WAKE_REQ), .IRQ(IRQ));

// File: sim/pin_source.sv
// far-side model: external pin drivers and cpu interrupt acceptance
`timescale 1ns/1ps
module pin_source (
  input  wire         clk,
  input  wire  [24:0] want,
  input  wire         irq,
  output logic [24:0] pins,
  output logic [7:0]  irq_count
);
  logic       last_irq = 1'b0;
  logic [7:0] rises    = 8'h00;
  assign irq_count = rises;
  // pins move one clock after the request, like registered board logic
  always @(posedge clk) begin
    pins     <= want;
    last_irq <= irq;
    if (irq && !last_irq)
      rises <= rises + 8'h01;
  end
endmodule // pin_source

// File: sim/pin_change_detector_tb_top.sv
// self-checking bench for the pin-change block
`timescale 1ns/1ps
`include "pin_change_map.vh"
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; $display("Error %s expected %h seen %h", n, e, g); end end
module pin_change_detector_tb_top;
  typedef struct { logic [1:0] g; logic [7:0] rise, fall, v0, v1, flag; } row_t;
  logic        sys_clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, rdata, seen;
  logic [7:0]  keep;
  logic [1:0]  htrans = 2'h0;
  logic [24:0] want = '0;
  logic [11:0] base;
  wire  [24:0] pins;
  wire  [31:0] hrdata;
  wire  [7:0]  irq_count;
  wire         hreadyout, hresp, change_irq, wake_req, irq;
  int          n_mismatch = 0, samples_checked = 0, cycles = 0, i;
  row_t rows[5] = '{'{2'h0, 8'h0F, 8'h00, 8'h00, 8'hFF, 8'h0F},
                    '{2'h1, 8'h00, 8'hF0, 8'hFF, 8'h00, 8'hF0},
                    '{2'h2, 8'h81, 8'h81, 8'h0F, 8'hF0, 8'h81},
                    '{2'h3, 8'hFF, 8'h00, 8'h00, 8'hFF, 8'h08},
                    '{2'h0, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00}};
  pin_change_detector #(.GROUP_WIDTH(8)) i_dut (.SYS_CLK(sys_clk), .RST_N(rst_n),
    .PIN_GROUP_A(pins[7:0]), .PIN_GROUP_B(pins[15:8]), .PIN_GROUP_C(pins[23:16]),
    .GROUP_E_PIN_THREE(pins[24]), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .CHANGE_IRQ(change_irq), .WAKE_REQ(wake_req),
    .IRQ(irq));
  pin_source i_pins (.clk(sys_clk), .want(want), .irq(irq), .pins(pins),
    .irq_count(irq_count));
  // ****************************************************************
  // clock, timeout and bus tasks
  // ****************************************************************
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end
  task stop_test;
    if (n_mismatch == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    hsel <= 1'b1;
    haddr <= {20'h00000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rdata = hrdata;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e, input string n);
    xfer(1'b0, a, 32'h0);
    `CHK(n, e, rdata)
  endtask
  task drive(input logic [1:0] g, input logic [7:0] v);
    @(posedge sys_clk);
    if (g == 2'h3) want[24] <= v[3];
    else want[8*g +: 8] <= v;
  endtask
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (i = 0; i <= 16; i++) rd(12'(4 * i), 32'h0, "reset value");
    wr(`PC_OFF_IRQ_EN, 32'h1);
    wr(`PC_OFF_IRQ_MASK, 32'h3);
    for (i = 0; i < 5; i++) begin
      base = 12'(rows[i].g) * 12'h00C;
      keep = rows[i].g == 2'h3 ? 8'h08 : 8'hFF;
      drive(rows[i].g, rows[i].v0);
      repeat (4) @(posedge sys_clk);
      wr(base, rows[i].rise);
      wr(base + 12'h004, rows[i].fall);
      rd(base, rows[i].rise & keep, "rise en");
      rd(base + 12'h004, rows[i].fall & keep, "fall en");
      wr(base + 12'h008, 32'h0);
      drive(rows[i].g, rows[i].v1);
      repeat (6) @(posedge sys_clk);
      rd(base + 12'h008, rows[i].flag, "pin flags");
      rd(`PC_OFF_IRQ_FLAG, rows[i].flag != 8'h00, "summary flag");
      `CHK("change irq", rows[i].flag != 8'h00, change_irq)
      wr(base + 12'h008, 32'h0);
    end
    wr(`PC_OFF_IRQ_EN, 32'h0);
    wr(`PC_OFF_RISE_A, 32'h1);
    drive(2'h0, 8'h01);
    repeat (6) @(posedge sys_clk);
    rd(`PC_OFF_FLAG_A, 32'h1, "flag with master off");
    `CHK("change irq off", 1'b0, change_irq)
    wr(`PC_OFF_IRQ_EN, 32'h1);
    repeat (2) @(posedge sys_clk);
    `CHK("change irq on", 1'b1, change_irq)
    `CHK("wake request", 1'b1, wake_req)
    xfer(1'b0, `PC_OFF_FLAG_A, 32'h0);
    seen = rdata;
    // read-modify-write that masks out only the bits already seen set
    xfer(1'b0, `PC_OFF_FLAG_A, 32'h0);
    wr(`PC_OFF_FLAG_A, rdata & ~seen);
    rd(`PC_OFF_FLAG_A, 32'h0, "flag cleared");
    `CHK("change irq cleared", 1'b0, change_irq)
    drive(2'h0, 8'h00);
    repeat (6) @(posedge sys_clk);
    wr(`PC_OFF_FLAG_A, 32'h2);
    // edge lands on the same clock as the flag write
    drive(2'h0, 8'h01);
    @(posedge sys_clk);
    wr(`PC_OFF_FLAG_A, 32'h0);
    rd(`PC_OFF_FLAG_A, 32'h1, "flag kept on clear");
    wr(`PC_OFF_IRQ_STAT, 32'h3);
    rd(`PC_OFF_IRQ_STAT, 32'h0, "status cleared");
    `CHK("irq cleared", 1'b0, irq)
    wr(`PC_OFF_IRQ_MASK, 32'h0);
    wr(`PC_OFF_FALL_A, 32'h1);
    drive(2'h0, 8'h00);
    repeat (6) @(posedge sys_clk);
    rd(`PC_OFF_IRQ_STAT, 32'h3, "status set");
    `CHK("irq masked", 1'b0, irq)
    wr(`PC_OFF_IRQ_MASK, 32'h2);
    `CHK("irq unmasked", 1'b1, irq)
    wr(`PC_OFF_IRQ_STAT, 32'h2);
    `CHK("irq after clear", 1'b0, irq)
    rd(`PC_OFF_IRQ_STAT, 32'h1, "status one left");
    wr(12'h044, 32'hFFFF_FFFF);
    rd(12'h044, 32'h0, "unmapped");
    wr(`PC_OFF_MOD_DIS, 32'h1);
    wr(`PC_OFF_RISE_A, 32'hFF);
    rd(`PC_OFF_RISE_A, 32'h0, "rise while off");
    rd(`PC_OFF_FLAG_A, 32'h0, "flag while off");
    drive(2'h0, 8'hFF);
    repeat (6) @(posedge sys_clk);
    `CHK("change irq off", 1'b0, change_irq)
    wr(`PC_OFF_MOD_DIS, 32'h0);
    rd(`PC_OFF_FLAG_A, 32'h0, "flag after on");
    wr(`PC_OFF_RISE_B, 32'hFF);
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(`PC_OFF_RISE_B, 32'h0, "rise after reset");
    `CHK("irq edges", 8'h02, irq_count)
    stop_test();
  end
endmodule // pin_change_detector_tb_top
